// >>> verilog/bms_device.sv
// device end: strap capture, memory decode, loader serial link
`timescale 1ns/1ps
`default_nettype none

// Contract
// - factory strap low selects normal execution
// - all straps high in reset: programming
// - programming mode starts loader after reset
// - loader ROM decoded F800H to FFFFH
// - loader ROM hidden in normal mode
// - normal mode decodes flash E000H to FFFFH
// - strap one becomes serial receive
// - strap two becomes serial transmit
// - reset pin input, driven on error
// - controller: reset low, straps high, wait
// - controller sends 5AH to open session
// - controller fills unused flash with FFH
// - eight data, no parity, one stop, 9600
// - echo good match byte, else silent
module bms_device #(
   parameter int BIT_CYCLES_P = bms_pkg::BIT_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   bms_link_if.dev link,
   input wire logic [15:0] cpu_addr_in,
   input wire logic cpu_rd_in,
   input wire logic [7:0] flash_rdata_in,
   input wire logic [7:0] rom_rdata_in,
   output logic [7:0] cpu_rdata_out,
   output logic flash_sel_out,
   output logic rom_sel_out,
   output logic core_run_out,
   output logic serial_mode_out,
   input wire logic err_reset_in,
   input wire logic gpio_bit0_o_in,
   input wire logic gpio_bit0_oe_in,
   input wire logic gpio_bit1_o_in,
   input wire logic gpio_bit1_oe_in,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic frame_err_out,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out
);
   localparam logic [15:0] BITC = 16'(BIT_CYCLES_P - 1);
   localparam logic [15:0] HALFC = 16'(BIT_CYCLES_P / 2 - 1);
   localparam logic [4:0] ERRC = 5'(bms_pkg::ERR_RST_CYCLES - 1);

   // ========================================
   // strap capture and mode
   logic strap_mode_q, strap_one_q, strap_two_q;
   logic run_q, serial_q;
   logic serial_sel;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         strap_mode_q <= 1'b0;
         strap_one_q <= 1'b0;
         strap_two_q <= 1'b0;
      end else if (!link.rst_lvl) begin
         strap_mode_q <= link.mode_lvl;
         strap_one_q <= link.bit0_lvl;
         strap_two_q <= link.bit1_lvl;
      end
   end

   assign serial_sel = strap_mode_q & strap_one_q & strap_two_q;

   // mode is frozen once running; only a new reset can move it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_q <= 1'b0;
         serial_q <= 1'b0;
      end else if (!link.rst_lvl) begin
         run_q <= 1'b0;
         serial_q <= 1'b0;
      end else if (!run_q) begin
         run_q <= 1'b1;
         serial_q <= serial_sel;
      end
   end

   assign core_run_out = run_q;
   assign serial_mode_out = serial_q;

   // ========================================
   // reset pin: pull low for a fixed burst on error
   logic [4:0] err_cnt_q;
   logic rst_oe_q;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         err_cnt_q <= '0;
         rst_oe_q <= 1'b0;
      end else if (err_reset_in & run_q) begin
         err_cnt_q <= ERRC;
         rst_oe_q <= 1'b1;
      end else if (err_cnt_q != '0) begin
         err_cnt_q <= err_cnt_q - 5'h1;
      end else begin
         rst_oe_q <= 1'b0;
      end
   end

   assign link.dev_rst_o = 1'b0;
   assign link.dev_rst_oe = rst_oe_q;

   // ========================================
   // memory decode, data captured same cycle as address
   logic rom_hit, flash_hit;
   logic [7:0] rdata_q;
   logic rom_sel_q, flash_sel_q;

   assign rom_hit = run_q & serial_q & (cpu_addr_in >= bms_pkg::ROM_BASE);
   assign flash_hit = run_q & ~rom_hit & (cpu_addr_in >= bms_pkg::FLASH_BASE);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_q <= bms_pkg::UNMAPPED_BYTE;
         rom_sel_q <= 1'b0;
         flash_sel_q <= 1'b0;
      end else begin
         rom_sel_q <= cpu_rd_in & rom_hit;
         flash_sel_q <= cpu_rd_in & flash_hit;
         if (cpu_rd_in) begin
            rdata_q <= rom_hit ? rom_rdata_in : (flash_hit ? flash_rdata_in : bms_pkg::UNMAPPED_BYTE);
         end
      end
   end

   assign cpu_rdata_out = rdata_q;
   assign rom_sel_out = rom_sel_q;
   assign flash_sel_out = flash_sel_q;

   // ========================================
   // serial receiver on strap one
   logic link_on;
   logic rxd;
   logic rx_busy_q, rx_prev_q;
   logic [15:0] rx_cnt_q;
   logic [3:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic rx_tick, byte_ok, byte_bad;

   assign link_on = run_q & serial_q;
   assign rxd = link.bit0_lvl;
   assign rx_tick = rx_busy_q & (rx_cnt_q == '0);
   assign byte_ok = rx_tick & (rx_bit_q == bms_pkg::FRAME_LAST) & rxd;
   assign byte_bad = rx_tick & (rx_bit_q == bms_pkg::FRAME_LAST) & ~rxd;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_busy_q <= 1'b0;
         rx_prev_q <= 1'b1;
         rx_cnt_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
      end else if (!link_on) begin
         rx_busy_q <= 1'b0;
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rxd;
         if (!rx_busy_q) begin
            if (rx_prev_q & ~rxd) begin
               rx_busy_q <= 1'b1;
               rx_cnt_q <= HALFC;
               rx_bit_q <= '0;
            end
         end else if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 16'h1;
         end else begin
            rx_cnt_q <= BITC;
            rx_bit_q <= rx_bit_q + 4'h1;
            // a start bit that is high again was a glitch
            if ((rx_bit_q == '0 && rxd) || rx_bit_q == bms_pkg::FRAME_LAST) begin
               rx_busy_q <= 1'b0;
            end else if (rx_bit_q != '0) begin
               rx_sh_q <= {rxd, rx_sh_q[7:1]};
            end
         end
      end
   end

   // ========================================
   // session sequencing
   bms_pkg::bms_dev_state_t st_q;
   logic match_ok;
   logic echo_q;
   logic tx_busy_q;
   logic tx_go, fifo_pop, fifo_vld;
   logic [7:0] fifo_data;

   assign match_ok = (st_q == bms_pkg::DS_MATCH) & byte_ok & (rx_sh_q == bms_pkg::MATCH_BYTE);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= bms_pkg::DS_OFF;
      end else if (!link_on) begin
         st_q <= bms_pkg::DS_OFF;
      end else begin
         unique case (st_q)
            bms_pkg::DS_OFF: st_q <= bms_pkg::DS_MATCH;
            bms_pkg::DS_MATCH: st_q <= match_ok ? bms_pkg::DS_SESSION : st_q;
            bms_pkg::DS_SESSION: st_q <= st_q;
         endcase
      end
   end

   // set wins over the clear taken when the echo starts
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         echo_q <= 1'b0;
      end else if (match_ok) begin
         echo_q <= 1'b1;
      end else if (tx_go | ~link_on) begin
         echo_q <= 1'b0;
      end
   end

   logic rxv_q, ferr_q;
   logic [7:0] rxd_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rxv_q <= 1'b0;
         ferr_q <= 1'b0;
         rxd_q <= '0;
      end else begin
         rxv_q <= byte_ok & (st_q == bms_pkg::DS_SESSION);
         ferr_q <= byte_bad;
         rxd_q <= byte_ok ? rx_sh_q : rxd_q;
      end
   end

   assign rx_valid_out = rxv_q;
   assign rx_data_out = rxd_q;
   assign frame_err_out = ferr_q;

   // ========================================
   // transmit path: fifo then serializer on strap two
   bms_fifo #(
      .W(bms_pkg::DATA_W),
      .D(bms_pkg::FIFO_DEPTH)
   ) bms_fifo_i (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .in_data_in(tx_data_in),
      .in_valid_in(tx_valid_in),
      .in_ready_out(tx_ready_out),
      .out_data_out(fifo_data),
      .out_valid_out(fifo_vld),
      .out_ready_in(fifo_pop)
   );

   logic [15:0] tx_cnt_q;
   logic [3:0] tx_bit_q;
   logic [8:0] tx_sh_q;
   logic txd_q;

   assign tx_go = link_on & ~tx_busy_q & (echo_q | (fifo_vld & (st_q == bms_pkg::DS_SESSION)));
   assign fifo_pop = tx_go & ~echo_q;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_busy_q <= 1'b0;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q <= '1;
         txd_q <= 1'b1;
      end else if (!link_on) begin
         tx_busy_q <= 1'b0;
         txd_q <= 1'b1;
      end else if (tx_go) begin
         tx_busy_q <= 1'b1;
         txd_q <= 1'b0;
         tx_sh_q <= {1'b1, echo_q ? bms_pkg::MATCH_BYTE : fifo_data};
         tx_cnt_q <= BITC;
         tx_bit_q <= '0;
      end else if (tx_busy_q) begin
         if (tx_cnt_q != '0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
         end else if (tx_bit_q == bms_pkg::FRAME_LAST) begin
            tx_busy_q <= 1'b0;
         end else begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            tx_cnt_q <= BITC;
         end
      end
   end

   // ========================================
   // pin roles; straps undriven from the first clock edge that sees reset low
   logic b0_oe_q, b0_o_q, b1_oe_q, b1_o_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         b0_oe_q <= 1'b0;
         b0_o_q <= 1'b1;
         b1_oe_q <= 1'b0;
         b1_o_q <= 1'b1;
      end else begin
         b0_oe_q <= link.rst_lvl & run_q & ~serial_q & gpio_bit0_oe_in;
         b0_o_q <= gpio_bit0_o_in;
         b1_oe_q <= link.rst_lvl & run_q & (serial_q | gpio_bit1_oe_in);
         b1_o_q <= serial_q ? txd_q : gpio_bit1_o_in;
      end
   end

   assign link.dev_bit0_oe = b0_oe_q;
   assign link.dev_bit0_o = b0_o_q;
   assign link.dev_bit1_oe = b1_oe_q;
   assign link.dev_bit1_o = b1_o_q;
endmodule : bms_device
`default_nettype wire

// >>> verilog/bms_pkg.sv
// shared constants and state types for the boot mode select link
package bms_pkg;
   // ========================================
   // clock and serial timing
   localparam int CLK_HZ = 125_000_000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int BAUD_DEFAULT = 9600;
   // rounds down: +0.006 percent rate error, well inside a 8n1 budget
   localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
   localparam int HOLD_TIME_US = 100;
   localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_PER_US;
   localparam int SETUP_TIME_US = 2000;
   localparam int SETUP_CYCLES = SETUP_TIME_US * CLK_PER_US;
   localparam int ECHO_WAIT_BITS = 30;
   localparam int ECHO_CYCLES = ECHO_WAIT_BITS * BIT_CYCLES;
   localparam int ERR_RST_CYCLES = 16;
   localparam logic [3:0] FRAME_LAST = 4'h9;

   // ========================================
   // bytes and address map
   localparam logic [7:0] MATCH_BYTE = 8'h5A;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
   localparam logic [15:0] ROM_BASE = 16'hF800;
   localparam logic [15:0] FLASH_BASE = 16'hE000;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;

   // ========================================
   // state types
   typedef enum {DS_OFF, DS_MATCH, DS_SESSION} bms_dev_state_t;
   typedef enum {HS_IDLE, HS_RESET, HS_SETUP, HS_SEND, HS_ECHO, HS_SESSION, HS_FAIL} bms_host_state_t;
endpackage : bms_pkg

// >>> verilog/bms_link_if.sv
// pin level link between programming controller and device
`timescale 1ns/1ps
`default_nettype none
interface bms_link_if;
   // ========================================
   // drivers of each end
   logic host_rst_o, host_rst_oe, dev_rst_o, dev_rst_oe;
   logic host_mode_o;
   logic host_bit0_o, host_bit0_oe, dev_bit0_o, dev_bit0_oe;
   logic host_bit1_o, host_bit1_oe, dev_bit1_o, dev_bit1_oe;

   // ========================================
   // resolved pin levels, reset and both bit lines pulled up, mode line driven by the controller
   logic rst_lvl, mode_lvl, bit0_lvl, bit1_lvl;
   assign rst_lvl = ~((host_rst_oe & ~host_rst_o) | (dev_rst_oe & ~dev_rst_o));
   assign mode_lvl = host_mode_o;
   assign bit0_lvl = dev_bit0_oe ? dev_bit0_o : (host_bit0_oe ? host_bit0_o : 1'b1);
   assign bit1_lvl = dev_bit1_oe ? dev_bit1_o : (host_bit1_oe ? host_bit1_o : 1'b1);

   modport dev (
      input rst_lvl, mode_lvl, bit0_lvl, bit1_lvl,
      output dev_rst_o, dev_rst_oe, dev_bit0_o, dev_bit0_oe, dev_bit1_o, dev_bit1_oe
   );
   modport host (
      input rst_lvl, bit0_lvl, bit1_lvl,
      output host_rst_o, host_rst_oe, host_mode_o, host_bit0_o, host_bit0_oe, host_bit1_o, host_bit1_oe
   );
endinterface : bms_link_if
`default_nettype wire

// >>> verilog/bms_fifo.sv
// byte fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bms_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [W-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   output logic [W-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   // pointers wrap naturally, so D must be a power of two
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q, cnt_d;
   logic ready_q;
   logic push, pop;

   assign push = in_valid_in & ready_q;
   assign pop = out_ready_in & (cnt_q != '0);
   assign in_ready_out = ready_q;
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];

   always_comb begin
      cnt_d = cnt_q;
      if (push & ~pop) begin
         cnt_d = cnt_q + (AW+1)'(1);
      end else if (pop & ~push) begin
         cnt_d = cnt_q - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b0;
      end else begin
         wr_q <= push ? wr_q + AW'(1) : wr_q;
         rd_q <= pop ? rd_q + AW'(1) : rd_q;
         cnt_q <= cnt_d;
         ready_q <= (cnt_d != (AW+1)'(D));
      end
   end
endmodule : bms_fifo
`default_nettype wire

// >>> verilog/bms_host.sv
// programming controller end: strap sequence and serial session
`timescale 1ns/1ps
`default_nettype none
module bms_host #(
   parameter int BIT_CYCLES_P = bms_pkg::BIT_CYCLES,
   parameter int HOLD_CYCLES_P = bms_pkg::HOLD_CYCLES,
   parameter int SETUP_CYCLES_P = bms_pkg::SETUP_CYCLES,
   parameter int ECHO_CYCLES_P = bms_pkg::ECHO_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   bms_link_if.host link,
   input wire logic start_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   input wire logic fill_in,
   output logic tx_ready_out,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   output logic session_out,
   output logic fail_out
);
   localparam logic [15:0] BITC = 16'(BIT_CYCLES_P - 1);
   localparam logic [15:0] HALFC = 16'(BIT_CYCLES_P / 2 - 1);

   // ========================================
   // sequencing
   bms_pkg::bms_host_state_t st_q;
   logic [23:0] tmr_q;
   logic tx_busy_q, tx_rdy_q, rx_busy_q, rx_prev_q, txd_q;
   logic [15:0] rx_cnt_q, tx_cnt_q;
   logic [3:0] rx_bit_q, tx_bit_q;
   logic [7:0] rx_sh_q;
   logic [8:0] tx_sh_q;
   logic rx_tick, byte_ok, byte_end, rx_on, take, tx_go;
   logic tmr_zero;

   assign tmr_zero = (tmr_q == '0);
   assign rx_tick = rx_busy_q & (rx_cnt_q == '0);
   assign byte_end = rx_tick & (rx_bit_q == bms_pkg::FRAME_LAST);
   assign byte_ok = byte_end & link.bit1_lvl;
   assign rx_on = (st_q == bms_pkg::HS_ECHO) | (st_q == bms_pkg::HS_SESSION);
   assign take = tx_valid_in & tx_rdy_q;
   assign tx_go = ~tx_busy_q & ((st_q == bms_pkg::HS_SEND) | take);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= bms_pkg::HS_IDLE;
         tmr_q <= '0;
      end else if (start_in && st_q != bms_pkg::HS_RESET) begin
         st_q <= bms_pkg::HS_RESET;
         tmr_q <= 24'(HOLD_CYCLES_P - 1);
      end else begin
         tmr_q <= tmr_zero ? tmr_q : tmr_q - 24'h1;
         unique case (st_q)
            bms_pkg::HS_IDLE, bms_pkg::HS_SESSION, bms_pkg::HS_FAIL: st_q <= st_q;
            bms_pkg::HS_RESET: if (tmr_zero) begin
               st_q <= bms_pkg::HS_SETUP;
               tmr_q <= 24'(SETUP_CYCLES_P - 1);
            end
            bms_pkg::HS_SETUP: if (tmr_zero) begin
               st_q <= bms_pkg::HS_SEND;
            end
            bms_pkg::HS_SEND: if (tx_go) begin
               st_q <= bms_pkg::HS_ECHO;
               tmr_q <= 24'(ECHO_CYCLES_P - 1);
            end
            bms_pkg::HS_ECHO: begin
               // any wrong byte or silence means the device refused
               if (byte_ok && rx_sh_q == bms_pkg::MATCH_BYTE) begin
                  st_q <= bms_pkg::HS_SESSION;
               end else if (byte_end || tmr_zero) begin
                  st_q <= bms_pkg::HS_FAIL;
               end
            end
         endcase
      end
   end

   // ========================================
   // serial receiver on strap two line
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_busy_q <= 1'b0;
         rx_prev_q <= 1'b1;
         rx_cnt_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
      end else if (!rx_on) begin
         rx_busy_q <= 1'b0;
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= link.bit1_lvl;
         if (!rx_busy_q) begin
            if (rx_prev_q & ~link.bit1_lvl) begin
               rx_busy_q <= 1'b1;
               rx_cnt_q <= HALFC;
               rx_bit_q <= '0;
            end
         end else if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 16'h1;
         end else begin
            rx_cnt_q <= BITC;
            rx_bit_q <= rx_bit_q + 4'h1;
            if ((rx_bit_q == '0 && link.bit1_lvl) || rx_bit_q == bms_pkg::FRAME_LAST) begin
               rx_busy_q <= 1'b0;
            end else if (rx_bit_q != '0) begin
               rx_sh_q <= {link.bit1_lvl, rx_sh_q[7:1]};
            end
         end
      end
   end

   // ========================================
   // serializer on strap one line
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_busy_q <= 1'b0;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q <= '1;
         txd_q <= 1'b1;
      end else if (tx_go) begin
         tx_busy_q <= 1'b1;
         txd_q <= 1'b0;
         if (st_q == bms_pkg::HS_SEND) begin
            tx_sh_q <= {1'b1, bms_pkg::MATCH_BYTE};
         end else begin
            tx_sh_q <= {1'b1, fill_in ? bms_pkg::FILL_BYTE : tx_data_in};
         end
         tx_cnt_q <= BITC;
         tx_bit_q <= '0;
      end else if (tx_busy_q) begin
         if (tx_cnt_q != '0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
         end else if (tx_bit_q == bms_pkg::FRAME_LAST) begin
            tx_busy_q <= 1'b0;
         end else begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            tx_cnt_q <= BITC;
         end
      end
   end

   // ========================================
   // pins and user outputs
   logic rst_oe_q, mode_q, b0_oe_q, b1_oe_q, rxv_q, sess_q, fail_q;
   logic [7:0] rxd_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_oe_q <= 1'b0;
         mode_q <= 1'b0;
         b0_oe_q <= 1'b0;
         b1_oe_q <= 1'b0;
         tx_rdy_q <= 1'b0;
         rxv_q <= 1'b0;
         rxd_q <= '0;
         sess_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         rst_oe_q <= (st_q == bms_pkg::HS_RESET);
         mode_q <= (st_q != bms_pkg::HS_IDLE);
         b0_oe_q <= (st_q != bms_pkg::HS_IDLE);
         b1_oe_q <= (st_q == bms_pkg::HS_RESET);
         tx_rdy_q <= (st_q == bms_pkg::HS_SESSION) & ~tx_busy_q & ~take;
         rxv_q <= byte_ok & (st_q == bms_pkg::HS_SESSION);
         rxd_q <= byte_ok ? rx_sh_q : rxd_q;
         sess_q <= (st_q == bms_pkg::HS_SESSION);
         fail_q <= (st_q == bms_pkg::HS_FAIL);
      end
   end

   assign link.host_rst_o = 1'b0;
   assign link.host_rst_oe = rst_oe_q;
   assign link.host_mode_o = mode_q;
   assign link.host_bit0_o = txd_q;
   assign link.host_bit0_oe = b0_oe_q;
   assign link.host_bit1_o = 1'b1;
   assign link.host_bit1_oe = b1_oe_q;
   assign tx_ready_out = tx_rdy_q;
   assign rx_data_out = rxd_q;
   assign rx_valid_out = rxv_q;
   assign session_out = sess_q;
   assign fail_out = fail_q;
endmodule : bms_host
`default_nettype wire

// >>> sim/bms_link_asserts.sv
// pin level assertions for the boot mode link
`timescale 1ns/1ps
`default_nettype none
module bms_link_asserts (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic rst_lvl,
   input wire logic host_rst_o,
   input wire logic host_rst_oe,
   input wire logic host_mode_o,
   input wire logic host_bit0_o,
   input wire logic host_bit0_oe,
   input wire logic host_bit1_oe,
   input wire logic dev_rst_o,
   input wire logic dev_rst_oe,
   input wire logic dev_bit0_oe,
   input wire logic dev_bit1_o,
   input wire logic dev_bit1_oe
);
   // ========================================
   // checks; bit lengths assume the bench's 16-cycle bit
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   AST_DEV_RST_LOW: assert property (dev_rst_oe |-> !dev_rst_o)
      else $error("device reset pin not driven low");
   AST_ERR_RST_LEN: assert property ($rose(dev_rst_oe) |-> dev_rst_oe[*8] ##1 dev_rst_oe[*8] ##1 !dev_rst_oe)
      else $error("error reset burst length wrong");
   AST_HOST_RST_LOW: assert property (host_rst_oe |-> !host_rst_o)
      else $error("controller reset pin not low");
   AST_STRAPS_IN_RST: assert property (host_rst_oe |-> host_mode_o && host_bit0_oe && host_bit0_o && host_bit1_oe)
      else $error("straps not high during reset");
   AST_RST_FIRST: assert property ($rose(host_mode_o) |-> host_rst_oe)
      else $error("mode strap raised outside reset");
   AST_PINS_IN_RST: assert property (!rst_lvl ##1 !rst_lvl |-> !dev_bit0_oe && !dev_bit1_oe)
      else $error("device drives strap pin in reset");
   AST_RX_NOT_DRIVEN: assert property (host_mode_o ##1 host_mode_o |-> !dev_bit0_oe)
      else $error("device drives receive line");
   AST_DEV_BIT_LEN: assert property ($fell(dev_bit1_o) && dev_bit1_oe |-> !dev_bit1_o[*8] ##1 !dev_bit1_o[*8])
      else $error("device low bit too short");
   AST_HOST_BIT_LEN: assert property ($fell(host_bit0_o) && host_bit0_oe |-> !host_bit0_o[*8] ##1 !host_bit0_o[*8])
      else $error("controller low bit too short");
   cover property ($rose(dev_rst_oe));
   cover property ($fell(dev_bit1_o) && dev_bit1_oe);
   cover property ($rose(host_mode_o));
endmodule : bms_link_asserts
`default_nettype wire

// >>> sim/bms_tb_top.sv
// self-checking bench joining controller and device ends
`timescale 1ns/1ps
`default_nettype none
module bms_tb_top;
   logic clk_in = 1'h0;
   logic resetn_in = 1'h0;
   logic start = 1'h0, fill = 1'h0, rd = 1'h0, err = 1'h0, g0 = 1'h0, htv = 1'h0, dtv = 1'h0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] hd = 8'h00, dd = 8'h00, rdata, hrx, drx;
   logic fsel, rsel, run, smode, drv, dtr, htr, hrv, sess, fail;
   int num_errors = 0, samples_checked = 0;
   bms_link_if link();
   bms_device #(.BIT_CYCLES_P(16)) bms_device_i (.clk_in(clk_in), .resetn_in(resetn_in), .link(link),
      .cpu_addr_in(addr), .cpu_rd_in(rd), .flash_rdata_in(addr[7:0]), .rom_rdata_in(~addr[7:0]),
      .cpu_rdata_out(rdata), .flash_sel_out(fsel), .rom_sel_out(rsel), .core_run_out(run),
      .serial_mode_out(smode), .err_reset_in(err), .gpio_bit0_o_in(addr[0]), .gpio_bit0_oe_in(g0),
      .gpio_bit1_o_in(addr[1]), .gpio_bit1_oe_in(g0), .rx_data_out(drx), .rx_valid_out(drv),
      .frame_err_out(), .tx_data_in(dd), .tx_valid_in(dtv), .tx_ready_out(dtr));
   // short counts keep the run brief
   bms_host #(.BIT_CYCLES_P(16), .HOLD_CYCLES_P(20), .SETUP_CYCLES_P(50), .ECHO_CYCLES_P(480)) bms_host_i (
      .clk_in(clk_in), .resetn_in(resetn_in), .link(link), .start_in(start), .tx_data_in(hd),
      .tx_valid_in(htv), .fill_in(fill), .tx_ready_out(htr), .rx_data_out(hrx), .rx_valid_out(hrv),
      .session_out(sess), .fail_out(fail));
   bms_link_asserts bms_link_asserts_i (.clk_in(clk_in), .resetn_in(resetn_in), .rst_lvl(link.rst_lvl),
      .host_rst_o(link.host_rst_o), .host_rst_oe(link.host_rst_oe), .host_mode_o(link.host_mode_o),
      .host_bit0_o(link.host_bit0_o), .host_bit0_oe(link.host_bit0_oe), .host_bit1_oe(link.host_bit1_oe),
      .dev_rst_o(link.dev_rst_o), .dev_rst_oe(link.dev_rst_oe), .dev_bit0_oe(link.dev_bit0_oe),
      .dev_bit1_o(link.dev_bit1_o), .dev_bit1_oe(link.dev_bit1_oe));
   // ========================================
   // helpers
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] s);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk_in);
      rd <= 1'h0;
      @(negedge clk_in);
      chk("rdata", e, rdata);
      chk("rom_flash_sel", {6'h00, s}, {6'h00, rsel, fsel});
   endtask : rdchk
   task automatic final_report;
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // ========================================
   // scenarios
   task automatic t_normal;
      g0 <= 1'h1;
      repeat (3) @(negedge clk_in);
      chk("run_mode", 8'h02, {6'h00, run, smode});
      chk("gpio_pin", 8'h00, {6'h00, link.bit1_lvl, link.bit0_lvl});
      @(posedge clk_in);
      g0 <= 1'h0;
      rdchk(16'hFFA5, 8'hA5, 2'h1);
      rdchk(16'hE012, 8'h12, 2'h1);
      rdchk(16'h0100, 8'h00, 2'h0);
   endtask : t_normal
   task automatic t_serial;
      int j;
      @(posedge clk_in);
      start <= 1'h1;
      @(posedge clk_in);
      start <= 1'h0;
      j = 0;
      do @(negedge clk_in); while (sess !== 1'h1 && ++j < 3000);
      chk("session", 8'h02, {6'h00, sess, fail});
      chk("run_mode", 8'h03, {6'h00, run, smode});
      rdchk(16'hF800, 8'hFF, 2'h2);
      rdchk(16'hFFFF, 8'h00, 2'h2);
      rdchk(16'hE001, 8'h01, 2'h1);
   endtask : t_serial
   task automatic t_fifo;
      int n, j;
      n = 0;
      @(posedge clk_in);
      dtv <= 1'h1;
      dd <= 8'h00;
      while (n < 20) begin
         @(negedge clk_in);
         if (dtr !== 1'h1) break;
         @(posedge clk_in);
         n++;
         dd <= n[7:0];
      end
      @(posedge clk_in);
      dtv <= 1'h0;
      // sixteen stored plus one already in the serializer
      chk("fifo_pushes", 8'h11, n[7:0]);
      for (int k = 0; k < n; k++) begin
         j = 0;
         do @(negedge clk_in); while (hrv !== 1'h1 && ++j < 400);
         chk("host_rx", k[7:0], hrx);
      end
   endtask : t_fifo
   task automatic t_host_tx;
      int j;
      for (int f = 0; f < 2; f++) begin
         @(posedge clk_in);
         htv <= 1'h1;
         hd <= 8'h3C;
         fill <= (f == 0);
         j = 0;
         do @(negedge clk_in); while (htr !== 1'h1 && ++j < 400);
         @(posedge clk_in);
         htv <= 1'h0;
         fill <= 1'h0;
         j = 0;
         do @(negedge clk_in); while (drv !== 1'h1 && ++j < 400);
         chk("dev_rx", f ? 8'h3C : 8'hFF, drx);
      end
   endtask : t_host_tx
   task automatic t_err;
      @(posedge clk_in);
      err <= 1'h1;
      @(posedge clk_in);
      err <= 1'h0;
      repeat (4) @(negedge clk_in);
      chk("err_reset", 8'h00, {6'h00, run, link.rst_lvl});
      repeat (40) @(negedge clk_in);
      chk("mode_again", 8'h03, {6'h00, run, smode});
   endtask : t_err
   initial forever #4 clk_in = ~clk_in;
   initial begin
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'h1;
      t_normal();
      t_serial();
      t_fifo();
      t_host_tx();
      t_err();
      final_report();
   end
   // whole sequence needs under 6000 cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      final_report();
   end
endmodule : bms_tb_top
`default_nettype wire
